// ---- design/src_clock_pkg.sv ----
// Shared constants, register layout and state types of the clock-request and power-down block.
// Assumes every edge strobe is a one-cycle pulse already aligned to sys_clk.
//
// Overview of operation
// - Stop-map A bits 4:0 let request A stop reference outputs 5..1; reset zero.
// - Stop-map B bit 7 maps output 8 (reset one); bits 4:0 outputs 5..1 (reset zero).
// - A request level counts only after staying equal on two reference complement rises.
// - Requests are active low and asynchronous; they are synchronised before use.
// - On request assertion stopped outputs restart together, 2 to 6 reference periods later.
// - A restarting output drives its true pin within 10 ns.
// - On request release every mapped output stops right after its next complement fall.
// - A request-stopped output rests low with neither pin driven.
// - Shared pin is supply-good until first sampled low, then power-down for good.
// - Power-down is active high, asynchronous, synchronised; its release powers back up.
// - Power-down high on two host complement rises holds single-ended outputs low next fall.
// - Differential outputs park on their next complement fall, within 4 periods.
// - Drive-mode zero parks with true pin high at double current, complement tri-stated.
// - Drive-mode one parks with both pins tri-stated.
// - All clocks are parked and held before the oscillators are turned off.
// - Video clock parks like the dot clock at 96 MHz, like references at 100 MHz.
// - Parking works for every host clock rate: 100, 133, 166 and 200 MHz.
// - Enable bit 7 gates request A and bit 6 request B; both reset disabled.
package src_clock_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] MAP_A_OFFSET     = 8'h0e;
	localparam logic [7:0] MAP_B_OFFSET     = 8'h0f;
	localparam logic [7:0] MAP_A_WRITE_MASK = 8'h1f;
	localparam logic [7:0] MAP_B_WRITE_MASK = 8'h9f;
	localparam logic [7:0] MAP_A_RESET      = 8'h80;
	localparam logic [7:0] MAP_B_RESET      = 8'h80;
	localparam logic [7:0] UNMAPPED_READ    = 8'h00;

	// ----------------------------------------------------------------
	// Output layout and timing
	// ----------------------------------------------------------------
	localparam int          SERIAL_REF_COUNT    = 8;
	localparam int          SHARED_MAP_OUTPUTS  = 5;
	localparam int          MAP_B_HIGH_OUTPUT   = 7;
	localparam int          CLK_PERIOD_NS       = 10;
	localparam int          DRIVE_TIME_NS       = 10;
	localparam int          DRIVE_CYCLES_RAW    = DRIVE_TIME_NS / CLK_PERIOD_NS;
	localparam int          DRIVE_CYCLES        = (DRIVE_CYCLES_RAW < 1) ? 1 : DRIVE_CYCLES_RAW;
	localparam logic [2:0]  RESTART_EDGES       = 3'h2;
	localparam logic [2:0]  RESTART_MAX_PERIODS = 3'h6;
	localparam logic [2:0]  PARK_MAX_PERIODS    = 3'h4;
	localparam logic        REQ_IDLE_LEVEL      = 1'b1;
	localparam logic        PIN_RESET_LEVEL     = 1'b1;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DIFF_RUN  = 2'b00,
		DIFF_STOP = 2'b01,
		DIFF_PARK = 2'b10
	} diff_state_type;

	typedef enum logic [1:0] {
		PIN_WAIT_GOOD = 2'b00,
		PIN_RUNNING   = 2'b01,
		PIN_PARKING   = 2'b10,
		PIN_OSC_OFF   = 2'b11
	} pin_state_type;

endpackage

// ---- design/level_filter.sv ----
// Two-flop synchroniser followed by a two-edge agreement filter.
// Assumes sample_edge is a one-cycle strobe on sys_clk.
`timescale 1ns/100ps
module level_filter #(
	parameter logic RESET_LEVEL = 1'b1
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// Pin and sampling edge
	input  wire logic pin_async,
	input  wire logic sample_edge,
	input  wire logic clear,
	// Results
	output logic      sync_level,
	output logic      level
);
	import src_clock_pkg::*;

	logic meta_q;
	logic sample_q;

	// ----------------------------------------------------------------
	// Synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q     <= RESET_LEVEL;
			sync_level <= RESET_LEVEL;
		end else if (clk_en) begin
			meta_q     <= pin_async;
			sync_level <= meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Agreement filter
	// ----------------------------------------------------------------
	// Clear realigns the filter when its sampling clock may have stood still
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_q <= RESET_LEVEL;
			level    <= RESET_LEVEL;
		end else if (clk_en) begin
			if (clear) begin
				sample_q <= sync_level;
				level    <= sync_level;
			end else if (sample_edge) begin
				sample_q <= sync_level;
				if (sync_level == sample_q) begin
					level <= sync_level;
				end
			end
		end
	end

endmodule

// ---- design/diff_park.sv ----
// Stop, restart and park control of one differential output pair.
// Assumes fall_edge and rise_edge are strobes of the pair's own complement clock.
`timescale 1ns/100ps
module diff_park (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// Requests and edges
	input  wire logic stop_req,
	input  wire logic park_req,
	input  wire logic drive_mode,
	input  wire logic fall_edge,
	input  wire logic rise_edge,
	// Pin control
	output logic      run,
	output logic      true_oe,
	output logic      comp_oe,
	output logic      park_high,
	output logic      parked
);
	import src_clock_pkg::*;

	diff_state_type state_q;
	diff_state_type state_d;
	logic [2:0]     restart_cnt_q;
	logic           restart_now;

	assign restart_now = !stop_req && rise_edge && (restart_cnt_q == RESTART_EDGES - 3'h1);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			DIFF_RUN: begin
				if (park_req && fall_edge) begin
					state_d = DIFF_PARK;
				end else if (stop_req && fall_edge) begin
					state_d = DIFF_STOP;
				end
			end
			DIFF_STOP: begin
				if (park_req && fall_edge) begin
					state_d = DIFF_PARK;
				end else if (restart_now) begin
					state_d = DIFF_RUN;
				end
			end
			DIFF_PARK: begin
				if (!park_req) begin
					state_d = stop_req ? DIFF_STOP : DIFF_RUN;
				end
			end
			default: state_d = DIFF_RUN;
		endcase
	end

	// ----------------------------------------------------------------
	// State and pin control
	// ----------------------------------------------------------------
	// Pins follow the next state so a restart drives the true pin in one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= DIFF_RUN;
			run       <= 1'b1;
			true_oe   <= 1'b1;
			comp_oe   <= 1'b1;
			park_high <= 1'b0;
			parked    <= 1'b0;
		end else if (clk_en) begin
			state_q   <= state_d;
			run       <= (state_d == DIFF_RUN);
			true_oe   <= (state_d == DIFF_RUN) || ((state_d == DIFF_PARK) && !drive_mode);
			comp_oe   <= (state_d == DIFF_RUN);
			park_high <= (state_d == DIFF_PARK) && !drive_mode;
			parked    <= (state_d == DIFF_PARK);
		end
	end

	// Counted rises make every pair sharing a request restart on the same edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			restart_cnt_q <= 3'h0;
		end else if (clk_en) begin
			if (stop_req || (state_q != DIFF_STOP) || restart_now) begin
				restart_cnt_q <= 3'h0;
			end else if (rise_edge) begin
				restart_cnt_q <= restart_cnt_q + 3'h1;
			end
		end
	end

endmodule

// ---- design/src_clock_request.sv ----
// Top of the clock-request and power-down block: stop maps, request filters,
// shared power pin sequencing and one controller per differential pair.
// Assumes edge strobes of the generated clocks arrive as sys_clk pulses.
`timescale 1ns/100ps
module src_clock_request #(
	parameter int REF_COUNT  = src_clock_pkg::SERIAL_REF_COUNT,
	parameter int DIFF_COUNT = src_clock_pkg::SERIAL_REF_COUNT + 3
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	// Request and power pins
	input  wire logic                  clock_request_a_n,
	input  wire logic                  clock_request_b_n,
	input  wire logic                  shared_power_pin,
	// Generated clock edge strobes
	input  wire logic                  ref_comp_rise,
	input  wire logic                  ref_comp_fall,
	input  wire logic                  host_comp_rise,
	input  wire logic                  host_comp_fall,
	input  wire logic                  dot_comp_fall,
	input  wire logic                  single_ended_fall,
	// Control bits
	input  wire logic                  request_a_enable,
	input  wire logic                  request_b_enable,
	input  wire logic                  video_select_100,
	input  wire logic [DIFF_COUNT-1:0] drive_mode,
	// Register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	input  wire logic [7:0]            reg_wdata,
	output logic      [7:0]            reg_rdata,
	// Differential pair control
	output logic      [DIFF_COUNT-1:0] differential_out_run,
	output logic      [DIFF_COUNT-1:0] differential_out_true_oe,
	output logic      [DIFF_COUNT-1:0] differential_out_comp_oe,
	output logic      [DIFF_COUNT-1:0] differential_out_park_high,
	// Power state
	output logic                       single_ended_hold_low,
	output logic                       oscillator_enable,
	output logic                       power_down_active
);
	import src_clock_pkg::*;

	localparam int HOST_IDX  = REF_COUNT;
	localparam int DOT_IDX   = REF_COUNT + 1;
	localparam int VIDEO_IDX = REF_COUNT + 2;
	localparam int DRIVE_BOUND = DRIVE_CYCLES;

	logic [7:0]            map_a_q;
	logic [7:0]            map_b_q;
	logic                  req_a_level;
	logic                  req_b_level;
	logic                  pin_sync;
	logic                  pin_level;
	logic                  pin_clear;
	pin_state_type         pin_state_q;
	pin_state_type         pin_state_d;
	logic [DIFF_COUNT-1:0] stop_vec;
	logic [DIFF_COUNT-1:0] fall_vec;
	logic [DIFF_COUNT-1:0] rise_vec;
	logic [DIFF_COUNT-1:0] parked_vec;
	logic                  all_parked;

	// ----------------------------------------------------------------
	// Stop-map registers
	// ----------------------------------------------------------------
	// Reserved bits are rebuilt from their reset value on every write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			map_a_q <= MAP_A_RESET;
			map_b_q <= MAP_B_RESET;
		end else if (clk_en && reg_write) begin
			if (reg_addr == MAP_A_OFFSET) begin
				map_a_q <= (reg_wdata & MAP_A_WRITE_MASK) | (MAP_A_RESET & ~MAP_A_WRITE_MASK);
			end
			if (reg_addr == MAP_B_OFFSET) begin
				map_b_q <= (reg_wdata & MAP_B_WRITE_MASK) | (MAP_B_RESET & ~MAP_B_WRITE_MASK);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= UNMAPPED_READ;
		end else if (clk_en && reg_read) begin
			case (reg_addr)
				MAP_A_OFFSET: reg_rdata <= map_a_q;
				MAP_B_OFFSET: reg_rdata <= map_b_q;
				default:      reg_rdata <= UNMAPPED_READ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin filters
	// ----------------------------------------------------------------
	level_filter #(.RESET_LEVEL(REQ_IDLE_LEVEL)) request_a_filter (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.pin_async   (clock_request_a_n),
		.sample_edge (ref_comp_rise),
		.clear       (1'b0),
		.sync_level  (),
		.level       (req_a_level)
	);

	level_filter #(.RESET_LEVEL(REQ_IDLE_LEVEL)) request_b_filter (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.pin_async   (clock_request_b_n),
		.sample_edge (ref_comp_rise),
		.clear       (1'b0),
		.sync_level  (),
		.level       (req_b_level)
	);

	// Host edges only sample; any host rate works the same way
	level_filter #(.RESET_LEVEL(PIN_RESET_LEVEL)) power_pin_filter (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.pin_async   (shared_power_pin),
		.sample_edge (host_comp_rise),
		.clear       (pin_clear),
		.sync_level  (pin_sync),
		.level       (pin_level)
	);

	// ----------------------------------------------------------------
	// Shared power pin sequencing
	// ----------------------------------------------------------------
	// Release is seen on the synchronised level because host edges stop with the oscillators
	always_comb begin
		pin_state_d = pin_state_q;
		pin_clear   = 1'b0;
		case (pin_state_q)
			PIN_WAIT_GOOD: begin
				if (!pin_level) begin
					pin_state_d = PIN_RUNNING;
				end
			end
			PIN_RUNNING: begin
				if (pin_level) begin
					pin_state_d = PIN_PARKING;
				end
			end
			PIN_PARKING: begin
				if (!pin_sync) begin
					pin_state_d = PIN_RUNNING;
					pin_clear   = 1'b1;
				end else if (all_parked && single_ended_hold_low) begin
					pin_state_d = PIN_OSC_OFF;
				end
			end
			PIN_OSC_OFF: begin
				if (!pin_sync) begin
					pin_state_d = PIN_RUNNING;
					pin_clear   = 1'b1;
				end
			end
			default: pin_state_d = PIN_WAIT_GOOD;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_state_q       <= PIN_WAIT_GOOD;
			power_down_active <= 1'b0;
			oscillator_enable <= 1'b1;
		end else if (clk_en) begin
			pin_state_q       <= pin_state_d;
			power_down_active <= (pin_state_d == PIN_PARKING) || (pin_state_d == PIN_OSC_OFF);
			oscillator_enable <= (pin_state_d != PIN_OSC_OFF);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			single_ended_hold_low <= 1'b0;
		end else if (clk_en) begin
			if (pin_state_d == PIN_RUNNING) begin
				single_ended_hold_low <= 1'b0;
			end else if (power_down_active && single_ended_fall) begin
				single_ended_hold_low <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-pair controllers
	// ----------------------------------------------------------------
	// Host, dot and video pairs have no request mapping and only park
	always_comb begin
		stop_vec = '0;
		fall_vec = '0;
		rise_vec = '0;
		for (int i = 0; i < REF_COUNT; i++) begin
			if (i < SHARED_MAP_OUTPUTS) begin
				stop_vec[i] = (request_a_enable && map_a_q[i] && req_a_level)
					|| (request_b_enable && map_b_q[i] && req_b_level);
			end else if (i == MAP_B_HIGH_OUTPUT) begin
				stop_vec[i] = request_b_enable && map_b_q[MAP_B_HIGH_OUTPUT] && req_b_level;
			end
			fall_vec[i] = ref_comp_fall;
			rise_vec[i] = ref_comp_rise;
		end
		fall_vec[HOST_IDX]  = host_comp_fall;
		fall_vec[DOT_IDX]   = dot_comp_fall;
		fall_vec[VIDEO_IDX] = video_select_100 ? ref_comp_fall : dot_comp_fall;
		rise_vec[VIDEO_IDX] = ref_comp_rise;
	end

	assign all_parked = &parked_vec;

	generate
		for (genvar g = 0; g < DIFF_COUNT; g++) begin : pair
			diff_park pair_ctrl (
				.sys_clk    (sys_clk),
				.rst_n      (rst_n),
				.clk_en     (clk_en),
				.stop_req   (stop_vec[g]),
				.park_req   (power_down_active),
				.drive_mode (drive_mode[g]),
				.fall_edge  (fall_vec[g]),
				.rise_edge  (rise_vec[g]),
				.run        (differential_out_run[g]),
				.true_oe    (differential_out_true_oe[g]),
				.comp_oe    (differential_out_comp_oe[g]),
				.park_high  (differential_out_park_high[g]),
				.parked     (parked_vec[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	logic [2:0] since_cnt_q;
	logic [2:0] park_cnt_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_cnt_q <= 3'h0;
			park_cnt_q  <= 3'h0;
		end else if (clk_en) begin
			if (stop_vec[0]) begin
				since_cnt_q <= 3'h0;
			end else if (ref_comp_rise && (since_cnt_q != 3'h7)) begin
				since_cnt_q <= since_cnt_q + 3'h1;
			end
			if (!power_down_active || parked_vec[0]) begin
				park_cnt_q <= 3'h0;
			end else if (ref_comp_fall && (park_cnt_q != 3'h7)) begin
				park_cnt_q <= park_cnt_q + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_map_a_write: assert property (clk_en && reg_write && (reg_addr == MAP_A_OFFSET)
		|=> map_a_q == (($past(reg_wdata) & 8'h1f) | 8'h80))
		else $error("stop map A write not stored");
	a_map_b_write: assert property (clk_en && reg_write && (reg_addr == MAP_B_OFFSET)
		|=> map_b_q == (($past(reg_wdata) & 8'h9f)))
		else $error("stop map B write not stored");
	a_reserved_read: assert property (clk_en && reg_read && (reg_addr == MAP_A_OFFSET)
		|=> reg_rdata[7:5] == 3'h4)
		else $error("reserved bits of stop map A wrong");
	a_filter_edge: assert property ($changed(req_a_level) |-> $past(ref_comp_rise))
		else $error("request level accepted without a reference edge");
	a_stop_cause: assert property ($fell(differential_out_run[0])
		|-> $past(stop_vec[0] && ref_comp_fall) || $past(power_down_active))
		else $error("reference pair stopped without cause");
	a_restart_window: assert property ($rose(differential_out_run[0]) && !$past(parked_vec[0])
		|-> (since_cnt_q >= RESTART_EDGES) && (since_cnt_q <= RESTART_MAX_PERIODS))
		else $error("restart outside 2 to 6 reference periods");
	a_true_driven: assert property ($rose(differential_out_run[0])
		|-> ##[0:DRIVE_BOUND] differential_out_true_oe[0])
		else $error("restarted pair true pin not driven");
	a_stopped_idle: assert property (!differential_out_run[0] && !parked_vec[0]
		|-> !differential_out_true_oe[0] && !differential_out_comp_oe[0])
		else $error("stopped pair still driven");
	a_park_mode0: assert property (parked_vec[0] && !$past(drive_mode[0])
		|-> differential_out_park_high[0] && differential_out_true_oe[0] && !differential_out_comp_oe[0])
		else $error("drive mode zero park wrong");
	a_park_mode1: assert property (parked_vec[0] && $past(drive_mode[0])
		|-> !differential_out_true_oe[0] && !differential_out_comp_oe[0])
		else $error("drive mode one park wrong");
	a_park_bound: assert property (park_cnt_q <= PARK_MAX_PERIODS)
		else $error("pair not parked within 4 periods");
	a_osc_after_park: assert property ($fell(oscillator_enable)
		|-> $past(all_parked && single_ended_hold_low))
		else $error("oscillators off before clocks parked");
	a_pin_latched: assert property (pin_state_q != PIN_WAIT_GOOD
		|=> pin_state_q != PIN_WAIT_GOOD)
		else $error("shared pin returned to supply-good role");
	a_se_hold: assert property ($rose(single_ended_hold_low)
		|-> $past(single_ended_fall && power_down_active))
		else $error("single-ended hold without power-down edge");

	c_request_cycle: cover property ($fell(differential_out_run[0]) ##[1:200] $rose(differential_out_run[0]));
	c_park_all: cover property ($rose(all_parked));
	c_osc_off: cover property ($fell(oscillator_enable) ##[1:200] $rose(oscillator_enable));

endmodule

// ---- verif/clock_partner.sv ----
// Far-side model: edge strobes of the generated clocks and the requesting devices.
// Assumes the bench drives want_a/want_b; strobes stand still while oscillators are off.
`timescale 1ns/100ps
module clock_partner (
	// Clock and control
	input  wire logic sys_clk,
	input  wire logic osc_on,
	input  wire logic want_a,
	input  wire logic want_b,
	// Request pins
	output logic      clock_request_a_n,
	output logic      clock_request_b_n,
	// Edge strobes
	output logic      ref_rise,
	output logic      ref_fall,
	output logic      host_rise,
	output logic      host_fall,
	output logic      dot_fall,
	output logic      se_fall
);
	logic [1:0] phase_q = 2'h0;
	// Pins move 3 ns off the grid, unrelated to any device clock
	assign #3 clock_request_a_n = ~want_a;
	assign #3 clock_request_b_n = ~want_b;
	// No edges while stopped: the real clocks do not run then
	always @(negedge sys_clk) begin
		phase_q   <= phase_q + 2'h1;
		ref_rise  <= osc_on && phase_q == 2'h0;
		ref_fall  <= osc_on && phase_q == 2'h2;
		host_rise <= osc_on && phase_q == 2'h1;
		host_fall <= osc_on && phase_q == 2'h3;
		dot_fall  <= osc_on && phase_q == 2'h3;
		se_fall   <= osc_on && phase_q == 2'h0;
	end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench of the clock-request and power-down block.
// Assumes a reference period of four sys_clk cycles from the partner model.
`timescale 1ns/100ps
module testbench;
	import src_clock_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
	logic        sys_clk = 1'b0, rst_n = 1'b0, pin = 1'b1, wr = 1'b0, rd = 1'b0;
	logic        want_a = 1'b1, want_b = 1'b1, en_a = 1'b0, en_b = 1'b0, vsel = 1'b0, ce = 1'b1;
	logic [10:0] mode = 11'h7fe;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, q;
	wire  [7:0]  rdata;
	wire  [10:0] run, toe, coe, phigh;
	wire         hold, osc, pd, ra_n, rb_n, rr, rf, hr, hf, df, sf;
	int          n_errors = 0, comparisons = 0, cyc = 0, n;
	row_type     rows [6] = '{'{8'h0e, 8'hff, 8'h9f}, '{8'h0e, 8'h60, 8'h80},
		'{8'h0f, 8'hff, 8'h9f}, '{8'h0f, 8'h60, 8'h00}, '{8'h20, 8'hff, 8'h00},
		'{8'h0f, 8'h81, 8'h81}};

	clock_partner far (.sys_clk(sys_clk), .osc_on(osc), .want_a(want_a), .want_b(want_b),
		.clock_request_a_n(ra_n), .clock_request_b_n(rb_n), .ref_rise(rr), .ref_fall(rf),
		.host_rise(hr), .host_fall(hf), .dot_fall(df), .se_fall(sf));
	src_clock_request uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce),
		.clock_request_a_n(ra_n), .clock_request_b_n(rb_n), .shared_power_pin(pin),
		.ref_comp_rise(rr), .ref_comp_fall(rf), .host_comp_rise(hr), .host_comp_fall(hf),
		.dot_comp_fall(df), .single_ended_fall(sf), .request_a_enable(en_a),
		.request_b_enable(en_b), .video_select_100(vsel), .drive_mode(mode),
		.reg_addr(addr), .reg_write(wr), .reg_read(rd), .reg_wdata(wdata), .reg_rdata(rdata),
		.differential_out_run(run), .differential_out_true_oe(toe),
		.differential_out_comp_oe(coe), .differential_out_park_high(phigh),
		.single_ended_hold_low(hold), .oscillator_enable(osc), .power_down_active(pd));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	always #5 sys_clk = ~sys_clk;
	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task wr8(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask
	task rd8(input logic [7:0] a, output logic [7:0] v);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		tick(1);
		v = rdata;
	endtask
	task wrap_up;
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		tick(6);
		rst_n = 1'b1;
		check(run, 11'h7ff);
		check({osc, pd, hold}, 3'h4);
		rd8(MAP_A_OFFSET, q);
		check(q, 8'h80);
		rd8(MAP_B_OFFSET, q);
		check(q, 8'h80);
		tick(20);
		check(pd, 1'b0);
		pin = 1'b0;
		tick(20);
		foreach (rows[i]) begin
			wr8(rows[i].a, rows[i].d);
			rd8(rows[i].a, q);
			check(q, rows[i].e);
		end
		// Request A stops output 1 only, then restarts it in 2..6 periods
		wr8(MAP_A_OFFSET, 8'h01);
		en_a = 1'b1;
		tick(20);
		check(run[0], 1'b1);
		want_a = 1'b0;
		for (n = 0; n < 40 && run[0] !== 1'b0; n++) tick(1);
		check({run[0], toe[0], coe[0]}, 3'h0);
		check(run[1], 1'b1);
		want_a = 1'b1;
		for (n = 0; n < 40 && run[0] !== 1'b1; n++) tick(1);
		check(n >= 8 && n <= 24, 1'b1);
		check(toe[0], 1'b1);
		// Request B: outputs 1 and 8 stop and resume together
		en_a = 1'b0;
		en_b = 1'b1;
		want_b = 1'b0;
		tick(40);
		check(run, 11'h77e);
		want_b = 1'b1;
		for (n = 0; n < 40 && run[0] !== 1'b1; n++) tick(1);
		check(run[7], 1'b1);
		en_b = 1'b0;
		want_b = 1'b0;
		tick(40);
		check(run, 11'h7ff);
		// Power-down: pair 0 parks high, others tri-state, then oscillators stop
		pin = 1'b1;
		for (n = 0; n < 40 && pd !== 1'b1; n++) tick(1);
		for (n = 0; n < 40 && coe[1] !== 1'b0; n++) tick(1);
		check(n <= 16, 1'b1);
		for (n = 0; n < 40 && osc !== 1'b0; n++) tick(1);
		check({pd, hold}, 2'h3);
		check({toe[0], phigh[0], coe[0]}, 3'h6);
		check({toe[10:1], coe[10:1]}, 20'h0);
		pin = 1'b0;
		tick(5);
		check({osc, pd, hold, run[1]}, 4'h9);
		// Second reset: power-down as the first state, video clock at 100 MHz
		rst_n = 1'b0;
		vsel = 1'b1;
		mode = 11'h000;
		tick(2);
		rst_n = 1'b1;
		check({osc, pd, hold, run}, 14'h27ff);
		tick(20);
		pin = 1'b1;
		for (n = 0; n < 40 && coe[9] !== 1'b0; n++) tick(1);
		check({coe[10], coe[9]}, 2'h2);
		for (n = 0; n < 40 && coe[0] !== 1'b0; n++) tick(1);
		check(coe[10], 1'b0);
		for (n = 0; n < 40 && osc !== 1'b0; n++) tick(1);
		check({toe, phigh}, 22'h3fffff);
		check(coe, 11'h000);
		// Clock enable low freezes the release; it lands once enable returns
		ce = 1'b0;
		pin = 1'b0;
		tick(8);
		check({osc, pd, hold}, 3'h3);
		ce = 1'b1;
		tick(5);
		check({osc, pd, hold}, 3'h4);
		wrap_up();
	end
endmodule
